// ===== src/gpio4_params.svh
// register offsets, field positions, reset values for the four-bit port
// assumes byte-wide registers on word-aligned wishbone addresses
`ifndef GPIO4_PARAMS_SVH
`define GPIO4_PARAMS_SVH
`define GPIO4_OFS_DIR      4'h0
`define GPIO4_OFS_OUT      4'h4
`define GPIO4_OFS_READBACK 4'h8
`define GPIO4_OFS_PULLUP   4'hC
`define GPIO4_PIN_HI       7
`define GPIO4_PIN_LO       4
`define GPIO4_PIN_RESET    4'h0
`define GPIO4_RSVD_READ    4'h0
`endif

// ===== src/gpio4_pkg.sv
// types shared by the four-bit port design
// assumes gpio4_params.svh supplies the numeric constants
package gpio4_pkg;
	typedef enum logic [1:0] {
		GPIO4_IDLE,
		GPIO4_ACK
	} gpio4_bus_state_t;
	typedef logic [3:0] gpio4_pins_t;
endpackage

// ===== src/gpio4_pin_cell.sv
// one port pin: drive enable, pull-up gating and readback select
// assumes inputs synchronous to the clock
`timescale 1ns/1ps
module gpio4_pin_cell (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic dir_bit,
	input  wire logic out_bit,
	input  wire logic pullup_bit,
	input  wire logic pin_in,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pullup_on,
	output logic      readback
);
	logic pin_out_d, pin_oe_d, pullup_d, readback_d;

	// next pin state from the pin's own control bits and its input
	always_comb begin
		pin_oe_d   = dir_bit;
		pin_out_d  = out_bit;
		pullup_d   = pullup_bit & ~dir_bit;
		readback_d = dir_bit ? out_bit : pin_in;
	end

	// register the pin outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out   <= 1'b0;
			pin_oe    <= 1'b0;
			pullup_on <= 1'b0;
			readback  <= 1'b0;
		end else begin
			pin_out   <= pin_out_d;
			pin_oe    <= pin_oe_d;
			pullup_on <= pullup_d;
			readback  <= readback_d;
		end
	end

	a_pullup_off_out: assert property (@(posedge clk) disable iff (rst)
		$past(dir_bit) |-> !pullup_on)
		else $error("pull-up on while pin is output");
	a_oe_follows_dir: assert property (@(posedge clk) disable iff (rst)
		pin_oe == $past(dir_bit))
		else $error("output enable does not follow direction");
endmodule

// ===== src/gpio4_port.sv
// four-bit general purpose port with wishbone classic register access
// assumes one 100 MHz clock, pins synchronous, external wire resolution
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "gpio4_params.svh"
module gpio4_port
	import gpio4_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic [3:0]  PORT_PIN_I,
	output logic      [3:0]  PORT_PIN_O,
	output logic      [3:0]  PORT_PIN_OE,
	output logic      [3:0]  PORT_PULLUP_ON
);
	gpio4_bus_state_t state_q, state_d;
	gpio4_pins_t      dir_q, dir_d, out_q, out_d, pu_q, pu_d;
	gpio4_pins_t      readback;
	logic [31:0]      dat_q, dat_d;
	logic             req, wr_en;

	assign req   = WB_CYC_I & WB_STB_I;
	assign wr_en = req & WB_WE_I & WB_SEL_I[0] & (state_q == GPIO4_IDLE);

	// register file next state; one-cycle ack per request
	always_comb begin
		state_d = state_q;
		dir_d   = dir_q;
		out_d   = out_q;
		pu_d    = pu_q;
		dat_d   = 32'h0000_0000;
		unique case (state_q)
			GPIO4_IDLE: begin
				if (req) begin
					state_d = GPIO4_ACK;
					if (wr_en) begin
						unique case (WB_ADR_I)
							`GPIO4_OFS_DIR: dir_d = WB_DAT_I[`GPIO4_PIN_HI:`GPIO4_PIN_LO];
							`GPIO4_OFS_OUT: out_d = WB_DAT_I[`GPIO4_PIN_HI:`GPIO4_PIN_LO];
							`GPIO4_OFS_PULLUP: pu_d = WB_DAT_I[`GPIO4_PIN_HI:`GPIO4_PIN_LO];
							default: ; // readback and unmapped ignore writes
						endcase
					end
					unique case (WB_ADR_I)
						`GPIO4_OFS_OUT:      dat_d = {24'h00_0000, out_q, `GPIO4_RSVD_READ};
						`GPIO4_OFS_READBACK: dat_d = {24'h00_0000, readback, `GPIO4_RSVD_READ};
						`GPIO4_OFS_PULLUP:   dat_d = {24'h00_0000, pu_q, `GPIO4_RSVD_READ};
						default:             dat_d = 32'h0000_0000; // direction reads as zero
					endcase
				end
			end
			GPIO4_ACK: state_d = GPIO4_IDLE;
		endcase
	end

	// register state, reset to all inputs, pull-ups off
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_q <= GPIO4_IDLE;
			dir_q   <= `GPIO4_PIN_RESET;
			out_q   <= `GPIO4_PIN_RESET;
			pu_q    <= `GPIO4_PIN_RESET;
			dat_q   <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			dir_q   <= dir_d;
			out_q   <= out_d;
			pu_q    <= pu_d;
			dat_q   <= dat_d;
		end
	end

	assign WB_ACK_O = (state_q == GPIO4_ACK);
	assign WB_DAT_O = dat_q;

	// one cell per pin, each on its own bit
	genvar i;
	for (i = 0; i < 4; i++) begin : g_pin
		gpio4_pin_cell u_cell (
			.clk        (MCLK),
			.rst        (RST),
			.dir_bit    (dir_q[i]),
			.out_bit    (out_q[i]),
			.pullup_bit (pu_q[i]),
			.pin_in     (PORT_PIN_I[i]),
			.pin_out    (PORT_PIN_O[i]),
			.pin_oe     (PORT_PIN_OE[i]),
			.pullup_on  (PORT_PULLUP_ON[i]),
			.readback   (readback[i])
		);
	end

	sequence s_write_to(logic [3:0] a);
		req && WB_WE_I && WB_SEL_I[0] && state_q == GPIO4_IDLE && WB_ADR_I == a;
	endsequence

	a_dir_write_lands: assert property (@(posedge MCLK) disable iff (RST)
		s_write_to(`GPIO4_OFS_DIR) |=> dir_q == $past(WB_DAT_I[7:4]))
		else $error("direction write lost");
	a_out_write_pin: assert property (@(posedge MCLK) disable iff (RST)
		s_write_to(`GPIO4_OFS_OUT) ##1 1'b1 |=> PORT_PIN_O == $past(out_q))
		else $error("output latch not on pins");
	a_readback_ro: assert property (@(posedge MCLK) disable iff (RST)
		s_write_to(`GPIO4_OFS_READBACK) |=> $stable(dir_q) && $stable(out_q) && $stable(pu_q))
		else $error("readback write changed state");
	a_ack_single: assert property (@(posedge MCLK) disable iff (RST)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_req_acked: assert property (@(posedge MCLK) disable iff (RST)
		req && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not acked next cycle");
	a_rsvd_zero: assert property (@(posedge MCLK) disable iff (RST)
		WB_ACK_O |-> WB_DAT_O[3:0] == 4'h0)
		else $error("reserved bits not zero");
	a_dir_read_zero: assert property (@(posedge MCLK) disable iff (RST)
		req && !WB_ACK_O && WB_ADR_I == `GPIO4_OFS_DIR |=> WB_DAT_O == 32'h0000_0000)
		else $error("direction read not zero");
	a_pullup_gate: assert property (@(posedge MCLK) disable iff (RST)
		PORT_PULLUP_ON != 4'h0 |-> (PORT_PULLUP_ON & PORT_PIN_OE) == 4'h0)
		else $error("pull-up on an output pin");
endmodule

// ===== dv/gpio4_board.sv
// board model of four port pins: an external driver, floating lines, pull-ups
// assumes the port drives pins through oe and drv_o, bit 0 is pin position 4
`timescale 1ns/1ps
module gpio4_board (
	input  wire logic       clk,
	input  wire logic [3:0] drv_o,
	input  wire logic [3:0] oe,
	input  wire logic [3:0] pull_on,
	input  wire logic [3:0] ext_en,
	input  wire logic [3:0] ext_val,
	output logic      [3:0] level
);
	logic [3:0] wander_q = 4'h5;
	// a floating undriven line never holds a steady level
	always_ff @(posedge clk) begin
		wander_q <= ~wander_q;
	end
	// port drive wins, then the board driver, then the pull-up, else floating
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			level[i] = oe[i] ? drv_o[i] : ext_en[i] ? ext_val[i] : pull_on[i] | wander_q[i];
		end
	end
endmodule

// ===== dv/four_bit_gpio_port_test.sv
// self-checking bench for the four-bit port: register table then hand tests
// assumes gpio4_port, gpio4_board and the wishbone offsets 0, 4, 8, c
`timescale 1ns/1ps
module four_bit_gpio_port_test;
	typedef struct {logic w; logic [3:0] a, s; logic [7:0] d, m, e;} gpio4_row_t;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
	logic [3:0] adr = 0, sel = 0, pin_i, pin_o, oe, pu;
	logic [31:0] wdat = 0, dat_o, rdat;
	int err_count = 0, samples_checked = 0, cycles = 0;
	// reserved bits are always written as 0
	gpio4_row_t rows[13] = '{'{0,4,15,0,8'hf0,0}, '{0,12,15,0,8'hf0,0}, '{0,8,15,0,8'h30,8'h10},
		'{1,12,15,8'hc0,0,0}, '{0,8,15,0,8'hf0,8'hd0}, '{1,4,15,8'ha0,0,0}, '{1,4,14,8'h50,0,0},
		'{0,4,15,0,8'hf0,8'ha0}, '{1,0,15,8'h30,0,0}, '{0,8,15,0,8'hf0,8'he0}, '{1,8,15,0,0,0},
		'{0,8,15,0,8'hf0,8'he0}, '{1,12,15,8'hf0,0,0}};
	always #5 clk = ~clk;
	gpio4_port uut (.MCLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.PORT_PIN_I(pin_i), .PORT_PIN_O(pin_o), .PORT_PIN_OE(oe), .PORT_PULLUP_ON(pu));
	// board drives pins 4 and 5 with 1 and 0, pins 6 and 7 float
	gpio4_board board (.clk(clk), .drv_o(pin_o), .oe(oe), .pull_on(pu), .ext_en(4'h3),
		.ext_val(4'h5), .level(pin_i));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled high
	task bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, 24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = dat_o;
		{cyc, stb} <= 2'b00;
		if (n >= 20) err_count++;
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			report_and_stop;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		check({pin_o, oe, pu}, 0);
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
			if (!rows[i].w) check(rdat[7:0] & rows[i].m, rows[i].e);
		end
		repeat (3) @(posedge clk);
		check({pin_o & oe, oe, pu}, 12'h23c);
		bus(0, 0, 15, 0);
		check(rdat, 0);
		rst <= 1;
		@(posedge clk);
		check({pin_o, oe, pu, ack}, 0);
		rst <= 0;
		bus(0, 4, 15, 0);
		check(rdat[7:4], 0);
		report_and_stop;
	end
endmodule
